// ===== rtl/irq_standby_map.svh
// constants for the interrupt priority and standby controller
// Function
// - seven fixed levels, zero to six; lowest-numbered pending level wins.
// - nonmaskable at vector 4, external pins share 16, soft trap 96.
// - timer 0 and timer 1 matches share level one, vector 8.
// - event counter match events share level three, vector 24.
// - counter input fall and converter done share level four, vector 32.
// - serial receive and transmit done share level five, vector 40.
// - halt opcode stops execution; clock, peripherals and state keep running.
// - halt ends on any unmasked request or on reset.
// - stop opcode halts the oscillator, memory retained.
// - opcode stop ends only on nonmaskable input or reset.
// - opcode stop wake waits a timer 1 programmed interval, 52.4 ms max.
// - readable standby indicator tells standby wake from power-up.
// - low stop request pin enters pin stop, oscillator halted.
// - stop pin high: wait fixed 52.4 ms, then start at address 0.
// - held reset lengthens pin stop wake; no resume before release. Here reset ends the wake at once and execution resumes on release.
// - zero-cross rising pin reads 0 until rise, then 1 with request.
// - zero-cross falling pin reads 1 until fall, then 0 with request.
// - directly driven external pins behave as ordinary digital inputs.
// - first external pin requests on a rising edge.
// - nonmaskable input requests on a falling edge.
`ifndef IRQ_STANDBY_MAP_SVH
`define IRQ_STANDBY_MAP_SVH

// ***********************************************************************
// vectors and timing
// ***********************************************************************
`define VEC_LEVEL0      8'h04
`define VEC_LEVEL1      8'h08
`define VEC_LEVEL2      8'h10
`define VEC_LEVEL3      8'h18
`define VEC_LEVEL4      8'h20
`define VEC_LEVEL5      8'h28
`define VEC_LEVEL6      8'h60
`define VEC_RESTART     8'h00
`define CLK_PERIOD_NS   20
`define STAB_TIME_US    52400
`define STAB_CYCLES     ((`STAB_TIME_US * 1000) / `CLK_PERIOD_NS)
`define NUM_LEVELS      7

`endif

// ===== rtl/irq_standby_pkg.sv
// types for the interrupt priority and standby controller
package irq_standby_pkg;
  typedef enum logic [2:0] {
    ST_RUN, ST_HALT, ST_STOP_OP, ST_WAKE_OP, ST_STOP_PIN, ST_WAKE_PIN
  } pwr_state_e;

  // one request line per event source
  typedef struct packed {
    logic timer0_match_req;
    logic timer1_match_req;
    logic evcnt_match0_req;
    logic evcnt_match1_req;
    logic evcnt_input_fall_req;
    logic adc_done_req;
    logic serial_rx_done_req;
    logic serial_tx_done_req;
    logic soft_trap_opcode;
  } periph_req_s;

  // what the core sees of the controller
  typedef struct packed {
    logic       irq_valid;
    logic [2:0] irq_level;
    logic [7:0] irq_vector;
    logic       exec_en;
    logic       osc_en;
    logic       restart;
    logic [7:0] restart_addr;
  } core_ctl_s;
endpackage : irq_standby_pkg

// ===== rtl/edge_catch.sv
// one pending request latch fed by a synchronised pin or core pulse
`timescale 1ns/1ps
`default_nettype none
module edge_catch #(
  parameter bit FALLING = 1'b0,
  parameter bit SYNC    = 1'b1
) (
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  input  wire logic i_in,
  input  wire logic i_ack,
  output logic      o_level,
  output logic      o_pend
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic pend;
  } st_s;
  st_s st_r;
  st_s st_nxt;
  logic lvl;
  logic hit;

  // a core pulse needs no synchroniser; a pin passes two flops
  assign lvl     = SYNC ? st_r.s2 : i_in;
  assign hit     = FALLING ? (st_r.prev & ~lvl) : (~st_r.prev & lvl);
  assign o_level = st_r.prev;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.s1   = i_in;
    st_nxt.s2   = st_r.s1;
    st_nxt.prev = lvl;
    // set wins over acknowledge so a fresh edge is never dropped
    st_nxt.pend = hit | (st_r.pend & ~i_ack);
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_r <= {1'b0 ^ FALLING, 1'b0 ^ FALLING, 1'b0 ^ FALLING, 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_pend = st_r.pend;
endmodule : edge_catch
`default_nettype wire

// ===== rtl/irq_priority_standby_ctrl.sv
// interrupt priority ranking and standby sequencing
`timescale 1ns/1ps
`default_nettype none
`include "irq_standby_map.svh"
module irq_priority_standby_ctrl #(
  parameter int STAB_CYCLES = `STAB_CYCLES
) (
  input  wire logic                        i_core_clk,
  input  wire logic                        i_rst,
  input  wire logic                        i_nmi_n,
  input  wire logic                        i_rising_ext_irq,
  input  wire logic                        i_falling_ext_irq,
  input  wire logic                        i_stop_n,
  input  wire irq_standby_pkg::periph_req_s i_req,
  input  wire logic [1:0]                  i_ext_mask,
  input  wire logic [4:0]                  i_lvl_mask,
  input  wire logic                        i_irq_ack,
  input  wire logic                        i_halt_opcode,
  input  wire logic                        i_stop_opcode,
  input  wire logic [22:0]                 i_wake_cycles,
  output var irq_standby_pkg::core_ctl_s   o_ctl,
  output logic                             o_rising_ext_level,
  output logic                             o_falling_ext_level,
  output logic                             o_standby_indicator
);
  import irq_standby_pkg::*;

  localparam int NSRC = 13;

  // ***********************************************************************
  // state
  // ***********************************************************************
  typedef struct packed {
    pwr_state_e  mode;
    logic [22:0] cnt;
    logic        sb;
    logic        restart;
    logic        stop_s1;
    logic        stop_s2;
    logic [2:0]  lvl;
    logic [7:0]  vec;
    logic        valid;
  } ctl_s;
  ctl_s st_r;
  ctl_s st_nxt;

  logic [NSRC-1:0] src_in;
  logic [NSRC-1:0] src_pend;
  logic [NSRC-1:0] src_ack;
  logic [NSRC-1:0] src_lvl;
  logic [6:0]      lvl_pend;
  logic [6:0]      lvl_open;
  logic [2:0]      win_lvl;
  logic            win_any;
  logic [7:0]      win_vec;
  logic [22:0]     wake_len;

  // ***********************************************************************
  // request capture: 0 nmi, 1-2 ext pins, 3 unused, 4..12 peripherals
  // ***********************************************************************
  assign src_in   = {i_req.soft_trap_opcode, i_req.serial_tx_done_req,
                     i_req.serial_rx_done_req, i_req.adc_done_req,
                     i_req.evcnt_input_fall_req, i_req.evcnt_match1_req,
                     i_req.evcnt_match0_req, i_req.timer1_match_req,
                     i_req.timer0_match_req, 1'b0, i_falling_ext_irq,
                     i_rising_ext_irq, i_nmi_n};

  generate
    for (genvar g = 0; g < NSRC; g++) begin : g_src
      if (g == 3) begin : g_unused
        assign src_pend[g] = 1'b0;
        assign src_lvl[g]  = 1'b0;
      end else if (g < 3) begin : g_pin
        // pins: synchronised, edge sensed, digital level kept;
        // the nonmaskable and falling pins sense a fall, the other a rise
        edge_catch #(
          .FALLING(g != 1),
          .SYNC   (1'b1)
        ) u_c (
          .i_core_clk(i_core_clk),
          .i_rst     (i_rst),
          .i_in      (src_in[g]),
          .i_ack     (src_ack[g]),
          .o_level   (src_lvl[g]),
          .o_pend    (src_pend[g])
        );
      end else begin : g_core
        edge_catch #(.FALLING(1'b0), .SYNC(1'b0)) u_c (
          .i_core_clk(i_core_clk),
          .i_rst     (i_rst),
          .i_in      (src_in[g]),
          .i_ack     (src_ack[g]),
          .o_level   (src_lvl[g]),
          .o_pend    (src_pend[g])
        );
      end
    end
  endgenerate

  // plain digital readback of the two maskable pins
  assign o_rising_ext_level  = src_lvl[1];
  assign o_falling_ext_level = src_lvl[2];

  // ***********************************************************************
  // grouping into levels, masking, ranking
  // ***********************************************************************
  always_comb begin
    lvl_pend[0] = src_pend[0];
    lvl_pend[1] = src_pend[4] | src_pend[5];
    lvl_pend[2] = (src_pend[1] & ~i_ext_mask[0]) |
                  (src_pend[2] & ~i_ext_mask[1]);
    lvl_pend[3] = src_pend[6] | src_pend[7];
    lvl_pend[4] = src_pend[8] | src_pend[9];
    lvl_pend[5] = src_pend[10] | src_pend[11];
    lvl_pend[6] = src_pend[12];
  end

  // level 0 and the trap cannot be masked; others follow the mask
  assign lvl_open = lvl_pend & {1'b1, ~i_lvl_mask[4:1], 1'b1, 1'b1} &
                    {5'h1f, ~i_lvl_mask[0], 1'b1};

  // lowest-numbered open level wins
  always_comb begin
    win_any = 1'b0;
    win_lvl = 3'h0;
    for (int i = `NUM_LEVELS - 1; i >= 0; i--) begin
      if (lvl_open[i]) begin
        win_any = 1'b1;
        win_lvl = 3'(i);
      end
    end
  end

  always_comb begin
    unique case (win_lvl)
      3'h0:    win_vec = `VEC_LEVEL0;
      3'h1:    win_vec = `VEC_LEVEL1;
      3'h2:    win_vec = `VEC_LEVEL2;
      3'h3:    win_vec = `VEC_LEVEL3;
      3'h4:    win_vec = `VEC_LEVEL4;
      3'h5:    win_vec = `VEC_LEVEL5;
      default: win_vec = `VEC_LEVEL6;
    endcase
  end

  // acknowledge clears only the sources of the level presented
  always_comb begin
    src_ack = 13'h0000;
    if (i_irq_ack && st_r.valid) begin
      unique case (st_r.lvl)
        3'h0:    src_ack = 13'h0001;
        3'h1:    src_ack = 13'h0030;
        3'h2:    src_ack = {10'h000, ~i_ext_mask, 1'b0} & 13'h0006;
        3'h3:    src_ack = 13'h00c0;
        3'h4:    src_ack = 13'h0300;
        3'h5:    src_ack = 13'h0c00;
        default: src_ack = 13'h1000;
      endcase
    end
  end

  // wake interval from timer 1 setting, capped at the fixed maximum
  assign wake_len = (i_wake_cycles == 23'h0) ? 23'h1 :
                    ((32'(i_wake_cycles) > 32'(STAB_CYCLES)) ?
                     23'(STAB_CYCLES) : i_wake_cycles);

  // ***********************************************************************
  // standby sequencer
  // ***********************************************************************
  always_comb begin
    st_nxt         = st_r;
    st_nxt.stop_s1 = i_stop_n;
    st_nxt.stop_s2 = st_r.stop_s1;
    st_nxt.restart = 1'b0;
    // presented level is re-registered from the winner each cycle; valid is only raised in run
    st_nxt.valid   = win_any && (st_r.mode == ST_RUN);
    st_nxt.lvl     = win_lvl;
    st_nxt.vec     = win_vec;
    if (!st_r.stop_s2) begin
      st_nxt.mode = ST_STOP_PIN;
      st_nxt.sb   = 1'b1;
      st_nxt.cnt  = 23'h0;
    end else begin
      unique case (st_r.mode)
        ST_RUN: begin
          if (i_stop_opcode) begin
            st_nxt.mode = ST_STOP_OP;
            st_nxt.sb   = 1'b1;
          end else if (i_halt_opcode) begin
            st_nxt.mode = ST_HALT;
            st_nxt.sb   = 1'b1;
          end
        end
        ST_HALT: begin
          if (win_any) begin
            st_nxt.mode = ST_RUN;
          end
        end
        ST_STOP_OP: begin
          if (src_pend[0]) begin
            st_nxt.mode = ST_WAKE_OP;
            st_nxt.cnt  = 23'h0;
          end
        end
        ST_WAKE_OP: begin
          st_nxt.cnt = st_r.cnt + 23'h1;
          if (st_r.cnt + 23'h1 >= wake_len) begin
            st_nxt.mode = ST_RUN;
          end
        end
        ST_STOP_PIN: begin
          st_nxt.mode = ST_WAKE_PIN;
          st_nxt.cnt  = 23'h0;
        end
        ST_WAKE_PIN: begin
          st_nxt.cnt = st_r.cnt + 23'h1;
          if (32'(st_r.cnt) + 32'h1 >= 32'(STAB_CYCLES)) begin
            st_nxt.mode    = ST_RUN;
            st_nxt.restart = 1'b1;
          end
        end
      endcase
    end
  end

  // reset ends any standby; the indicator survives it to tell wake apart
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_r.mode    <= ST_RUN;
      st_r.cnt     <= 23'h0;
      st_r.restart <= 1'b0;
      st_r.stop_s1 <= 1'b1;
      st_r.stop_s2 <= 1'b1;
      st_r.lvl     <= 3'h0;
      st_r.vec     <= 8'h00;
      st_r.valid   <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ***********************************************************************
  // outputs
  // ***********************************************************************
  assign o_standby_indicator = st_r.sb;

  // one process drives the whole struct so it has a single driver
  always_comb begin
    o_ctl.irq_valid    = st_r.valid;
    o_ctl.irq_level    = st_r.lvl;
    o_ctl.irq_vector   = st_r.vec;
    o_ctl.exec_en      = (st_r.mode == ST_RUN) && !i_rst;
    o_ctl.osc_en       = (st_r.mode != ST_STOP_OP) &&
                         (st_r.mode != ST_STOP_PIN);
    o_ctl.restart      = st_r.restart;
    o_ctl.restart_addr = `VEC_RESTART;
  end

  // ***********************************************************************
  // checks
  // ***********************************************************************
  a_nmi_wins_rank: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (st_r.mode == ST_RUN && lvl_open[0]) |=> (o_ctl.irq_level == 3'h0))
    else $error("nonmaskable not ranked first");
  a_vec_level_two: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (o_ctl.irq_valid && o_ctl.irq_level == 3'h2) |->
    (o_ctl.irq_vector == 8'h10))
    else $error("external vector wrong");
  a_vec_timer_lvl: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (o_ctl.irq_valid && o_ctl.irq_level == 3'h1) |->
    (o_ctl.irq_vector == 8'h08))
    else $error("timer vector wrong");
  a_halt_no_exec: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (st_r.mode == ST_RUN && i_halt_opcode && !i_stop_opcode && st_r.stop_s2)
    |=> (!o_ctl.exec_en && o_ctl.osc_en))
    else $error("halt did not stop execution");
  // no request may be offered to the core while it is parked
  a_valid_run_only: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (st_r.mode != ST_RUN) |=> !o_ctl.irq_valid)
    else $error("request shown outside run");
  a_halt_wakes: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (st_r.mode == ST_HALT && win_any && st_r.stop_s2) |=> o_ctl.exec_en)
    else $error("halt not left on open request");
  a_stop_osc_off: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (st_r.mode == ST_RUN && i_stop_opcode && st_r.stop_s2) |=>
    !o_ctl.osc_en)
    else $error("stop left oscillator on");
  a_stop_only_nmi: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (st_r.mode == ST_STOP_OP && !src_pend[0] && st_r.stop_s2) |=>
    (st_r.mode == ST_STOP_OP))
    else $error("stop left without nmi");
  a_wake_op_cap: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (st_r.mode == ST_WAKE_OP) |-> (32'(st_r.cnt) < 32'(STAB_CYCLES)))
    else $error("opcode wake beyond cap");
  a_pin_stop_in: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    !st_r.stop_s2 |=> (st_r.mode == ST_STOP_PIN) ##0 !o_ctl.osc_en)
    else $error("pin stop not entered");
  a_restart_zero: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    o_ctl.restart |-> (o_ctl.exec_en && $past(st_r.mode) == ST_WAKE_PIN))
    else $error("restart without pin wake");
  // the fixed span ends in a restart pulse with execution enabled
  a_pin_wake_end: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (st_r.mode == ST_WAKE_PIN && st_r.stop_s2 &&
     32'(st_r.cnt) + 32'h1 >= 32'(STAB_CYCLES)) |=>
    (o_ctl.restart && o_ctl.exec_en))
    else $error("pin wake did not restart");
  a_pend_kept: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (src_pend[12] && !src_ack[12]) |=> src_pend[12])
    else $error("pending trap lost");
endmodule : irq_priority_standby_ctrl
`default_nettype wire

// ===== verif/core_model.sv
// core side model: accepts the shown interrupt after a set delay
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_rst,
  input  wire irq_standby_pkg::core_ctl_s i_ctl,
  input  wire logic [3:0]                i_delay,
  output logic                           o_irq_ack,
  output logic                           o_acc_stb,
  output logic [7:0]                     o_acc_vec,
  output logic [2:0]                     o_acc_lvl
);
  import irq_standby_pkg::*;

  logic [3:0] wait_cnt;
  logic [2:0] hold_cnt;

  // ***********************************************************************
  // acceptance
  // ***********************************************************************
  initial begin
    o_irq_ack = 1'b0;
    o_acc_stb = 1'b0;
  end

  // ack only while valid stands; hold off for four cycles after an accept,
  // otherwise a stale valid would be accepted twice
  always @(negedge i_core_clk) begin
    o_irq_ack <= 1'b0;
    o_acc_stb <= 1'b0;
    if (i_rst) begin
      wait_cnt <= 4'h0;
      hold_cnt <= 3'h0;
    end else if (hold_cnt != 3'h0) begin
      hold_cnt <= hold_cnt - 3'h1;
    end else if (i_ctl.irq_valid) begin
      if (wait_cnt >= i_delay) begin
        o_irq_ack <= 1'b1;
        o_acc_stb <= 1'b1;
        o_acc_vec <= i_ctl.irq_vector;
        o_acc_lvl <= i_ctl.irq_level;
        wait_cnt  <= 4'h0;
        hold_cnt  <= 3'h4;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule : core_model
`default_nettype wire

// ===== verif/tb_top.sv
// self-checking bench for the priority and standby controller
`timescale 1ns/1ps
`default_nettype none
`include "irq_standby_map.svh"
module tb_top;
  import irq_standby_pkg::*;
  localparam int STAB = 20;
  logic        clk, rst, nmi_n, rise_p, fall_p, stop_n, ack, halt_op, stop_op;
  periph_req_s req;
  logic [1:0]  ext_mask;
  logic [4:0]  lvl_mask;
  logic [22:0] wake;
  core_ctl_s   ctl;
  logic        rise_lvl, fall_lvl, sb, acc_stb;
  logic [3:0]  delay;
  logic [7:0]  acc_vec;
  logic [2:0]  acc_lvl;
  int          n_errors, cmp_count, n, it;
  logic [6:0]  open_l, held_l;
  logic [31:0] r;

  irq_priority_standby_ctrl #(.STAB_CYCLES(STAB)) i_dut (
    .i_core_clk(clk), .i_rst(rst), .i_nmi_n(nmi_n),
    .i_rising_ext_irq(rise_p), .i_falling_ext_irq(fall_p),
    .i_stop_n(stop_n), .i_req(req), .i_ext_mask(ext_mask),
    .i_lvl_mask(lvl_mask), .i_irq_ack(ack), .i_halt_opcode(halt_op),
    .i_stop_opcode(stop_op), .i_wake_cycles(wake), .o_ctl(ctl),
    .o_rising_ext_level(rise_lvl), .o_falling_ext_level(fall_lvl),
    .o_standby_indicator(sb));
  core_model i_core (
    .i_core_clk(clk), .i_rst(rst), .i_ctl(ctl), .i_delay(delay),
    .o_irq_ack(ack), .o_acc_stb(acc_stb), .o_acc_vec(acc_vec),
    .o_acc_lvl(acc_lvl));

  // ***********************************************************************
  // expectations and checks
  // ***********************************************************************
  function automatic logic [7:0] vec_of(input int l);
    case (l)
      0:       return `VEC_LEVEL0;
      1:       return `VEC_LEVEL1;
      2:       return `VEC_LEVEL2;
      3:       return `VEC_LEVEL3;
      4:       return `VEC_LEVEL4;
      5:       return `VEC_LEVEL5;
      default: return `VEC_LEVEL6;
    endcase
  endfunction : vec_of
  // struct bit 8 is timer0 down to bit 0 soft trap
  function automatic int lvl_of(input int b);
    return (b >= 7) ? 1 : (b >= 5) ? 3 : (b >= 3) ? 4 : (b >= 1) ? 5 : 6;
  endfunction : lvl_of
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit
  // wait for the core model to accept, then compare level and vector
  task automatic expect_irq(input int l);
    int k;
    for (k = 0; k < 80 && acc_stb !== 1'b1; k++) @(posedge clk);
    chk_bit(k < 80, 1'b1);
    chk_byte(acc_vec, vec_of(l));
    chk_byte({5'h0, acc_lvl}, l[7:0]);
    @(posedge clk);
  endtask : expect_irq
  task automatic pulse(input logic [8:0] v);
    @(negedge clk) req = periph_req_s'(v);
    @(negedge clk) req = '0;
  endtask : pulse
  task automatic wait_exec(output int c);
    c = 0;
    while (ctl.exec_en !== 1'b1 && c < 400) begin
      @(negedge clk);
      c++;
    end
  endtask : wait_exec
  task automatic test_done;
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  always #10 clk = ~clk;
  // a hang is cut short well beyond the expected run length
  initial begin
    #600000;
    n_errors++;
    test_done();
  end

  // ***********************************************************************
  // main sequence
  // ***********************************************************************
  initial begin
    {clk, rst, rise_p, halt_op, stop_op} = 5'b01000;
    {nmi_n, fall_p, stop_n} = 3'b111;
    req = '0;
    ext_mask = 2'h0;
    lvl_mask = 5'h00;
    wake = 23'h5;
    delay = 4'h0;
    n_errors = 0;
    cmp_count = 0;
    void'($urandom(64934));
    repeat (4) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    // every peripheral request line alone gives its level's vector
    for (int b = 8; b >= 0; b--) begin
      pulse(9'h1 << b);
      expect_irq(lvl_of(b));
    end
    chk_bit(rise_lvl, 1'b0);
    chk_bit(fall_lvl, 1'b1);
    @(negedge clk) rise_p = 1'b1;
    expect_irq(2);
    chk_bit(rise_lvl, 1'b1);
    @(negedge clk) fall_p = 1'b0;
    expect_irq(2);
    chk_bit(fall_lvl, 1'b0);
    // masked pin edge waits, then is served once the mask drops
    @(negedge clk) {ext_mask, rise_p, fall_p} = 4'b0101;
    repeat (4) @(negedge clk);
    rise_p = 1'b1;
    repeat (8) @(negedge clk);
    chk_bit(ctl.irq_valid, 1'b0);
    ext_mask = 2'h0;
    expect_irq(2);
    @(negedge clk) rise_p = 1'b0;
    @(negedge clk) nmi_n = 1'b0;
    expect_irq(0);
    @(negedge clk) nmi_n = 1'b1;
    // random bursts: open levels in ascending order, masked ones kept
    for (it = 0; it < 24; it++) begin
      @(negedge clk) r = $urandom;
      delay = {1'b0, r[16:14]};
      lvl_mask = r[13:9];
      {open_l, held_l} = '0;
      for (int b = 0; b < 9; b++)
        if (r[b]) begin
          if (lvl_of(b) == 6 || !r[8 + lvl_of(b)]) open_l[lvl_of(b)] = 1'b1;
          else held_l[lvl_of(b)] = 1'b1;
        end
      pulse(r[8:0]);
      for (int l = 1; l < 7; l++)
        if (open_l[l]) expect_irq(l);
      @(negedge clk) lvl_mask = 5'h00;
      for (int l = 1; l < 7; l++)
        if (held_l[l]) expect_irq(l);
    end
    // halt: a masked request leaves it idle, an open one wakes it
    delay = 4'h0;
    @(negedge clk) lvl_mask = 5'h01;
    @(negedge clk) halt_op = 1'b1;
    @(negedge clk) halt_op = 1'b0;
    pulse(9'h100);
    repeat (8) @(negedge clk);
    chk_bit(ctl.exec_en, 1'b0);
    chk_bit(ctl.osc_en, 1'b1);
    pulse(9'h008);
    wait_exec(n);
    chk_bit(n < 10, 1'b1);
    expect_irq(4);
    @(negedge clk) lvl_mask = 5'h00;
    expect_irq(1);
    // opcode stop ignores maskable requests, wakes on nmi after wake span
    @(negedge clk) stop_op = 1'b1;
    @(negedge clk) stop_op = 1'b0;
    repeat (3) @(negedge clk);
    chk_bit(ctl.osc_en, 1'b0);
    pulse(9'h100);
    repeat (10) @(negedge clk);
    chk_bit(ctl.exec_en, 1'b0);
    nmi_n = 1'b0;
    wait_exec(n);
    chk_bit(n >= 5 && n < 40, 1'b1);
    chk_bit(sb, 1'b1);
    expect_irq(0);
    expect_irq(1);
    @(negedge clk) nmi_n = 1'b1;
    // pin stop: fixed span, restart at address zero
    @(negedge clk) stop_n = 1'b0;
    repeat (6) @(negedge clk);
    chk_bit(ctl.osc_en, 1'b0);
    chk_bit(ctl.exec_en, 1'b0);
    stop_n = 1'b1;
    n = 0;
    while (ctl.restart !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk_bit(n >= STAB && n <= STAB + 8, 1'b1);
    chk_byte(ctl.restart_addr, 8'h00);
    // pin stop again, reset held in the wake span keeps execution off until release
    @(negedge clk) stop_n = 1'b0;
    repeat (8) @(negedge clk);
    stop_n = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b1;
    for (int k = 0; k < 40; k++) begin
      @(negedge clk);
      chk_bit(ctl.exec_en, 1'b0);
    end
    rst = 1'b0;
    wait_exec(n);
    chk_bit(n < 10, 1'b1);
    chk_bit(sb, 1'b1);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
